// >>> pio_params.svh
`ifndef PIO_PARAMS_SVH
`define PIO_PARAMS_SVH
`define PIO_OFS_A_OE 8'h0C
`define PIO_OFS_B_OE 8'h0D
`define PIO_OFS_C_OE 8'h1A
`define PIO_OFS_D_OE 8'h1B
`define PIO_OFS_DRV_A 8'h08
`define PIO_OFS_DRV_B 8'h09
`define PIO_OFS_DRV_C 8'h16
`define PIO_OFS_DRV_D 8'h17
`define PIO_OFS_DIR_A 8'h04
`define PIO_OFS_DIR_B 8'h05
`define PIO_OFS_DIR_C 8'h12
`define PIO_OFS_DIR_D 8'h13
`define PIO_OFS_PMODE0 8'hB0
`define PIO_OFS_PMODE3 8'hC7
`define PIO_OFS_PCFG 8'hE0
`define PIO_PM0_APD_BIT 1
`define PIO_PM0_TURBO_OFF_BIT 3
`define PIO_PM3_FPD_BIT 1
`define PIO_PCFG_ZERO_PWR_BIT 0
`define PIO_PCFG_CSI_EN_BIT 1
`define PIO_PCFG_CLKIN_EN_BIT 2
`define PIO_PCFG_STATUS_PINS_BIT 3
`define PIO_PCFG_RDY_EN_BIT 4
`define PIO_PCFG_STBY_EN_BIT 5
`define PIO_PCFG_PERIPH_EN_BIT 6
`define PIO_C_MASK 8'h9C
`define PIO_D_MASK 8'h06
`define PIO_RESET_BYTE 8'h00
`define PIO_APD_TIMEOUT 16
`endif

// >>> pio_pkg.sv
package pio_pkg;
   typedef enum logic [2:0] {
      PIO_MODE_MCU,
      PIO_MODE_OMC,
      PIO_MODE_IMC,
      PIO_MODE_ADDR,
      PIO_MODE_PERIPH
   } pio_mode_t;
   typedef struct packed {
      logic [7:0] a;
      logic [7:0] b;
      logic [7:0] c;
      logic [7:0] d;
   } pio_port_bus_t;
   typedef enum {PIO_PWR_RUN, PIO_PWR_DOWN} pio_pwr_t;
endpackage : pio_pkg

// >>> pio_port_ctrl.sv
`timescale 1ns/1ps
`include "pio_params.svh"
// Functional notes
// - status bit 1 means driver on
// - port A/B status at 0Ch, 0Dh
// - port C status only bits 7,4,3,2
// - port D status only bits 2,1
// - port A status resets to 00h
// - port A has five pin modes
// - A0-3 fast slew, A4-7 open drain
// - port B four modes, no peripheral
// - B0-3 fast slew, B4-7 open drain
// - port C only pins 2,3,4,7 usable
// - status pins 3,4 used together exclusively
// - C3 optional ready/busy output
// - C4 optional backup-supply indicator
// - C2,3,4,7 selectable open drain
// - port D modes and fast slew
// - D1 clocks macrocells and idle counter
// - chip-select high forces memories standby
// - memories wake on address change only
// - idle counter timeout shuts bus buffers
// - non-address signals still reach logic
// - forced power-down bit enters power-down
// - status shows final output enable
// - B0h bit 1 enables idle counter
// - B0h bit 3 turns turbo off
module pio_port_ctrl #(
   parameter int APD_TIMEOUT = `PIO_APD_TIMEOUT
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // host register port
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [7:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   output logic [7:0] bus_rdata,
   input wire logic [15:0] cpu_addr,
   // per-port mode and logic-array sources
   input wire pio_pkg::pio_mode_t mode_a,
   input wire pio_pkg::pio_mode_t mode_b,
   input wire pio_pkg::pio_mode_t mode_c,
   input wire pio_pkg::pio_mode_t mode_d,
   input wire pio_pkg::pio_port_bus_t pt_oe,
   input wire pio_pkg::pio_port_bus_t pt_out,
   input wire pio_pkg::pio_port_bus_t mcu_out,
   input wire logic [7:0] addr_latched,
   input wire logic periph_sel,
   input wire logic periph_rd,
   input wire logic [7:0] periph_data,
   input wire logic [1:0] ecs,
   input wire logic flash_ready,
   input wire logic sram_on_backup,
   input wire logic isp_progress_flag,
   input wire logic isp_error_flag,
   // pins
   input wire pio_pkg::pio_port_bus_t pin_in,
   output pio_pkg::pio_port_bus_t pin_out,
   output pio_pkg::pio_port_bus_t pin_oe,
   output pio_pkg::pio_port_bus_t pin_fast_slew,
   output pio_pkg::pio_port_bus_t pin_open_drain,
   // logic-array and memory side
   output pio_pkg::pio_port_bus_t pin_to_array,
   output logic macrocell_clk_en,
   output logic mem_standby,
   output logic mem_wake,
   output logic bus_buf_off,
   output logic turbo_off,
   output logic logic_zero_power
);
   logic [7:0] dir_a, dir_b, dir_c, dir_d;
   logic [7:0] drv_a, drv_b, drv_c, drv_d;
   logic [7:0] pmode0, pmode3, pcfg;
   logic [7:0] s1_a, s1_b, s1_c, s1_d, s2_a, s2_b, s2_c, s2_d, s3_a, s3_b, s3_c, s3_d;
   logic [7:0] in_a, in_b, in_c, in_d;
   logic [15:0] addr_q;
   logic [$clog2(APD_TIMEOUT+1)-1:0] idle_cnt;
   logic apd_expired;
   logic clk_d1_prev;
   pio_pkg::pio_pwr_t pwr_state;
   logic [7:0] next_oe_a, next_oe_b, next_oe_c, next_oe_d;
   logic [7:0] next_out_a, next_out_b, next_out_c, next_out_d;
   logic status_pins, bus_act;
   // host-written control; status offsets not decoded for write
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         dir_a <= `PIO_RESET_BYTE;
         dir_b <= `PIO_RESET_BYTE;
         dir_c <= `PIO_RESET_BYTE;
         dir_d <= `PIO_RESET_BYTE;
         drv_a <= `PIO_RESET_BYTE;
         drv_b <= `PIO_RESET_BYTE;
         drv_c <= `PIO_RESET_BYTE;
         drv_d <= `PIO_RESET_BYTE;
         pmode0 <= `PIO_RESET_BYTE;
         pmode3 <= `PIO_RESET_BYTE;
         pcfg <= `PIO_RESET_BYTE;
      end else if (bus_wr) begin
         case (bus_addr)
            `PIO_OFS_DIR_A: dir_a <= bus_wdata;
            `PIO_OFS_DIR_B: dir_b <= bus_wdata;
            `PIO_OFS_DIR_C: dir_c <= bus_wdata & `PIO_C_MASK;
            `PIO_OFS_DIR_D: dir_d <= bus_wdata & `PIO_D_MASK;
            `PIO_OFS_DRV_A: drv_a <= bus_wdata;
            `PIO_OFS_DRV_B: drv_b <= bus_wdata;
            `PIO_OFS_DRV_C: drv_c <= bus_wdata & `PIO_C_MASK;
            `PIO_OFS_DRV_D: drv_d <= bus_wdata & `PIO_D_MASK;
            `PIO_OFS_PMODE0: pmode0 <= bus_wdata;
            `PIO_OFS_PMODE3: pmode3 <= bus_wdata;
            `PIO_OFS_PCFG: pcfg <= bus_wdata;
            default: ;
         endcase
      end
   end
   // pin synchronisers: change counts once stages 2 and 3 agree
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         {s1_a, s1_b, s1_c, s1_d} <= 32'h00000000;
         {s2_a, s2_b, s2_c, s2_d} <= 32'h00000000;
         {s3_a, s3_b, s3_c, s3_d} <= 32'h00000000;
         {in_a, in_b, in_c, in_d} <= 32'h00000000;
      end else begin
         {s1_a, s1_b, s1_c, s1_d} <= pin_in;
         {s2_a, s2_b, s2_c, s2_d} <= {s1_a, s1_b, s1_c, s1_d};
         {s3_a, s3_b, s3_c, s3_d} <= {s2_a, s2_b, s2_c, s2_d};
         in_a <= (s2_a & s3_a) | (in_a & (s2_a | s3_a));
         in_b <= (s2_b & s3_b) | (in_b & (s2_b | s3_b));
         in_c <= (s2_c & s3_c) | (in_c & (s2_c | s3_c));
         in_d <= (s2_d & s3_d) | (in_d & (s2_d | s3_d));
      end
   end
   assign status_pins = pcfg[`PIO_PCFG_STATUS_PINS_BIT];
   // final output enable and data per pin
   always_comb begin
      case (mode_a)
         pio_pkg::PIO_MODE_MCU: begin next_oe_a = dir_a; next_out_a = mcu_out.a; end
         pio_pkg::PIO_MODE_OMC: begin next_oe_a = pt_oe.a; next_out_a = pt_out.a; end
         pio_pkg::PIO_MODE_ADDR: begin next_oe_a = 8'hFF; next_out_a = addr_latched; end
         pio_pkg::PIO_MODE_PERIPH: begin
            next_oe_a = {8{periph_sel & periph_rd & pcfg[`PIO_PCFG_PERIPH_EN_BIT]}};
            next_out_a = periph_data;
         end
         default: begin next_oe_a = 8'h00; next_out_a = 8'h00; end
      endcase
      case (mode_b)
         pio_pkg::PIO_MODE_MCU: begin next_oe_b = dir_b; next_out_b = mcu_out.b; end
         pio_pkg::PIO_MODE_OMC: begin next_oe_b = pt_oe.b; next_out_b = pt_out.b; end
         pio_pkg::PIO_MODE_ADDR: begin next_oe_b = 8'hFF; next_out_b = addr_latched; end
         default: begin next_oe_b = 8'h00; next_out_b = 8'h00; end
      endcase
      case (mode_c)
         pio_pkg::PIO_MODE_MCU: begin next_oe_c = dir_c; next_out_c = mcu_out.c; end
         pio_pkg::PIO_MODE_OMC: begin next_oe_c = pt_oe.c; next_out_c = pt_out.c; end
         default: begin next_oe_c = 8'h00; next_out_c = 8'h00; end
      endcase
      if (status_pins) begin
         next_oe_c[4:3] = 2'b11;
         next_out_c[4:3] = {isp_error_flag, isp_progress_flag};
      end else begin
         if (pcfg[`PIO_PCFG_RDY_EN_BIT]) begin
            next_oe_c[3] = 1'b1;
            next_out_c[3] = flash_ready;
         end
         if (pcfg[`PIO_PCFG_STBY_EN_BIT]) begin
            next_oe_c[4] = 1'b1;
            next_out_c[4] = sram_on_backup;
         end
      end
      next_oe_c = next_oe_c & `PIO_C_MASK;
      next_out_c = next_out_c & `PIO_C_MASK;
      case (mode_d)
         pio_pkg::PIO_MODE_MCU: begin next_oe_d = dir_d; next_out_d = mcu_out.d; end
         pio_pkg::PIO_MODE_OMC: begin next_oe_d = 8'h06; next_out_d = {5'h00, ecs, 1'b0}; end
         default: begin next_oe_d = 8'h00; next_out_d = 8'h00; end
      endcase
      if (pcfg[`PIO_PCFG_CLKIN_EN_BIT]) next_oe_d[1] = 1'b0;
      if (pcfg[`PIO_PCFG_CSI_EN_BIT]) next_oe_d[2] = 1'b0;
      next_oe_d = next_oe_d & `PIO_D_MASK;
      next_out_d = next_out_d & `PIO_D_MASK;
   end
   // registered pins; status reads the same flops
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pin_oe <= '0;
         pin_out <= '0;
         pin_fast_slew <= '0;
         pin_open_drain <= '0;
         pin_to_array <= '0;
      end else begin
         pin_oe <= {next_oe_a, next_oe_b, next_oe_c, next_oe_d};
         pin_out <= {next_out_a, next_out_b, next_out_c, next_out_d};
         pin_fast_slew <= {drv_a & 8'h0F, drv_b & 8'h0F, 8'h00, drv_d};
         pin_open_drain <= {drv_a & 8'hF0, drv_b & 8'hF0, drv_c, 8'h00};
         // non-address pins stay live in power-down
         pin_to_array <= {in_a, in_b, in_c & `PIO_C_MASK, in_d & `PIO_D_MASK};
      end
   end
   // register read-back
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         bus_rdata <= 8'h00;
      end else if (bus_rd) begin
         case (bus_addr)
            `PIO_OFS_A_OE: bus_rdata <= pin_oe.a;
            `PIO_OFS_B_OE: bus_rdata <= pin_oe.b;
            `PIO_OFS_C_OE: bus_rdata <= pin_oe.c & `PIO_C_MASK;
            `PIO_OFS_D_OE: bus_rdata <= pin_oe.d & `PIO_D_MASK;
            `PIO_OFS_DIR_A: bus_rdata <= dir_a;
            `PIO_OFS_DIR_B: bus_rdata <= dir_b;
            `PIO_OFS_DIR_C: bus_rdata <= dir_c;
            `PIO_OFS_DIR_D: bus_rdata <= dir_d;
            `PIO_OFS_DRV_A: bus_rdata <= drv_a;
            `PIO_OFS_DRV_B: bus_rdata <= drv_b;
            `PIO_OFS_DRV_C: bus_rdata <= drv_c;
            `PIO_OFS_DRV_D: bus_rdata <= drv_d;
            `PIO_OFS_PMODE0: bus_rdata <= pmode0;
            `PIO_OFS_PMODE3: bus_rdata <= pmode3;
            `PIO_OFS_PCFG: bus_rdata <= pcfg;
            default: bus_rdata <= 8'h00;
         endcase
      end
   end
   assign bus_act = bus_wr | bus_rd;
   // idle counter ticks on synced rising edges of pin D1
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         clk_d1_prev <= 1'b0;
         idle_cnt <= '0;
         apd_expired <= 1'b0;
      end else begin
         clk_d1_prev <= in_d[1];
         if (!pmode0[`PIO_PM0_APD_BIT] || bus_act) begin
            idle_cnt <= '0;
            apd_expired <= 1'b0;
         end else if (pcfg[`PIO_PCFG_CLKIN_EN_BIT] && in_d[1] && !clk_d1_prev) begin
            if (idle_cnt == ($bits(idle_cnt))'(APD_TIMEOUT - 1)) apd_expired <= 1'b1;
            else idle_cnt <= idle_cnt + 1'b1;
         end
      end
   end
   // power state and memory standby
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pwr_state <= pio_pkg::PIO_PWR_RUN;
         bus_buf_off <= 1'b0;
         mem_standby <= 1'b1;
         mem_wake <= 1'b0;
         addr_q <= 16'h0000;
         turbo_off <= 1'b0;
         logic_zero_power <= 1'b0;
         macrocell_clk_en <= 1'b0;
      end else begin
         case (pwr_state)
            pio_pkg::PIO_PWR_RUN: if (apd_expired || pmode3[`PIO_PM3_FPD_BIT]) pwr_state <= pio_pkg::PIO_PWR_DOWN;
            pio_pkg::PIO_PWR_DOWN: if (!apd_expired && !pmode3[`PIO_PM3_FPD_BIT]) pwr_state <= pio_pkg::PIO_PWR_RUN;
            default: pwr_state <= pio_pkg::PIO_PWR_RUN;
         endcase
         bus_buf_off <= (pwr_state == pio_pkg::PIO_PWR_DOWN);
         if (pwr_state == pio_pkg::PIO_PWR_RUN) addr_q <= cpu_addr;
         // one-shot wake per address change, blocked by chip-select or power-down
         mem_wake <= (pwr_state == pio_pkg::PIO_PWR_RUN) && (cpu_addr != addr_q)
                     && !(pcfg[`PIO_PCFG_CSI_EN_BIT] && in_d[2]);
         mem_standby <= !((pwr_state == pio_pkg::PIO_PWR_RUN) && (cpu_addr != addr_q)
                     && !(pcfg[`PIO_PCFG_CSI_EN_BIT] && in_d[2]));
         turbo_off <= pmode0[`PIO_PM0_TURBO_OFF_BIT];
         logic_zero_power <= pcfg[`PIO_PCFG_ZERO_PWR_BIT];
         macrocell_clk_en <= pcfg[`PIO_PCFG_CLKIN_EN_BIT] && in_d[1] && !clk_d1_prev;
      end
   end
   status_ro_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      bus_rd && bus_addr == `PIO_OFS_A_OE |=> bus_rdata == $past(pin_oe.a))
      else $error("port A status read wrong");
   c_mask_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (pin_oe.c & 8'h63) == 8'h00)
      else $error("port C test pins show enable");
   d_mask_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (pin_oe.d & 8'hF9) == 8'h00)
      else $error("port D unused bits set");
   csi_standby_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      pcfg[`PIO_PCFG_CSI_EN_BIT] && in_d[2] |=> mem_standby && !mem_wake)
      else $error("memory woke under chip-select");
   fpd_enter_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      pmode3[`PIO_PM3_FPD_BIT] |-> ##2 bus_buf_off)
      else $error("forced power-down not entered");
   apd_restart_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      bus_act |=> idle_cnt == '0 && !apd_expired)
      else $error("bus activity did not restart counter");
   apd_off_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !pmode0[`PIO_PM0_APD_BIT] |=> !apd_expired)
      else $error("counter ran while disabled");
   down_no_wake_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      bus_buf_off |-> !mem_wake)
      else $error("memory woke in power-down");
   turbo_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      ##1 turbo_off == $past(pmode0[`PIO_PM0_TURBO_OFF_BIT]))
      else $error("turbo control not followed");
endmodule : pio_port_ctrl

// >>> pio_host_model.sv
`timescale 1ns/1ps
module pio_host_model (
   // clock
   input wire logic clk_sys,
   // register bus
   output logic bus_wr,
   output logic bus_rd,
   output logic [7:0] bus_addr,
   output logic [7:0] bus_wdata,
   // address bus
   output logic [15:0] cpu_addr
);
   initial begin
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_addr = 8'h00;
      bus_wdata = 8'h00;
      cpu_addr = 16'h0000;
   end
   // one strobe cycle; address and data flip once released
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus_wr <= w;
      bus_rd <= ~w;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge clk_sys);
      bus_wr <= 1'b0;
      bus_rd <= 1'b0;
      bus_addr <= ~a;
      bus_wdata <= ~d;
   endtask : acc
   task automatic move(input logic [15:0] a);
      @(posedge clk_sys);
      cpu_addr <= a;
   endtask : move
endmodule : pio_host_model

// >>> pio_port_ctrl_tb.sv
`timescale 1ns/1ps
module pio_port_ctrl_tb;
   logic clk_sys, arst_n, bus_wr, bus_rd, periph_sel, periph_rd, flash_ready, sram_on_backup;
   logic isp_progress_flag, isp_error_flag, macrocell_clk_en, mem_standby, mem_wake, bus_buf_off;
   logic turbo_off, logic_zero_power;
   logic [7:0] bus_addr, bus_wdata, bus_rdata, addr_latched, periph_data, r;
   logic [15:0] cpu_addr;
   logic [1:0] ecs;
   pio_pkg::pio_mode_t mode_a, mode_b, mode_c, mode_d;
   pio_pkg::pio_port_bus_t pt_oe, pt_out, mcu_out, pin_in, pin_out, pin_oe;
   pio_pkg::pio_port_bus_t pin_fast_slew, pin_open_drain, pin_to_array;
   int err_total = 0;
   int total_checks = 0;
   int cycles = 0;
   int wakes = 0;
   int clkc = 0;
   int n0;
   logic [7:0] exp_q[$];
   logic [7:0] dir_ofs[4] = '{8'h04, 8'h05, 8'h12, 8'h13};
   logic [7:0] st_ofs[4] = '{8'h0C, 8'h0D, 8'h1A, 8'h1B};
   logic [7:0] drv_ofs[4] = '{8'h08, 8'h09, 8'h16, 8'h17};
   logic [7:0] msk[4] = '{8'hFF, 8'hFF, 8'h9C, 8'h06};
   logic [7:0] fs_exp[4] = '{8'h0F, 8'h0F, 8'h00, 8'h06};
   logic [7:0] od_exp[4] = '{8'hF0, 8'hF0, 8'h9C, 8'h00};
   logic [7:0] m_exp[5] = '{8'h5A, 8'hC3, 8'h00, 8'hFF, 8'hFF};
   logic [7:0] cf[3] = '{8'h08, 8'h10, 8'h20};
   logic [7:0] cf_exp[3] = '{8'h18, 8'h08, 8'h10};

   pio_host_model i_pio_host_model (.clk_sys, .bus_wr, .bus_rd, .bus_addr, .bus_wdata, .cpu_addr);
   pio_port_ctrl #(.APD_TIMEOUT(4)) i_pio_port_ctrl (.clk_sys, .arst_n, .bus_wr, .bus_rd, .bus_addr,
      .bus_wdata, .bus_rdata, .cpu_addr, .mode_a, .mode_b, .mode_c, .mode_d, .pt_oe, .pt_out, .mcu_out,
      .addr_latched, .periph_sel, .periph_rd, .periph_data, .ecs, .flash_ready, .sram_on_backup,
      .isp_progress_flag, .isp_error_flag, .pin_in, .pin_out, .pin_oe, .pin_fast_slew, .pin_open_drain,
      .pin_to_array, .macrocell_clk_en, .mem_standby, .mem_wake, .bus_buf_off, .turbo_off,
      .logic_zero_power);

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : tally_and_finish
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_pio_host_model.acc(1'b1, a, d);
   endtask : wr
   // the expected byte is noted before the strobe goes out
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      i_pio_host_model.acc(1'b0, a, 8'h00);
   endtask : rd
   task automatic d1_edges(input int n);
      repeat (n) begin
         pin_in.d[1] <= 1'b1;
         cyc(6);
         pin_in.d[1] <= 1'b0;
         cyc(6);
      end
   endtask : d1_edges
   task automatic done(input string s);
      $display("test %s done", s);
   endtask : done

   always @(posedge clk_sys) begin
      if (bus_rd === 1'b1) begin
         #1;
         chk(bus_rdata, exp_q.pop_front());
      end
   end
   always @(posedge clk_sys) begin
      if (mem_wake === 1'b1) wakes++;
      if (macrocell_clk_en === 1'b1) clkc++;
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         tally_and_finish();
      end
   end

   initial begin
      void'($urandom(20012));
      arst_n = 1'b0;
      {periph_sel, periph_rd, flash_ready, sram_on_backup, isp_progress_flag, isp_error_flag} = 6'($urandom);
      mode_a = pio_pkg::PIO_MODE_MCU;
      mode_b = pio_pkg::PIO_MODE_MCU;
      mode_c = pio_pkg::PIO_MODE_MCU;
      mode_d = pio_pkg::PIO_MODE_MCU;
      pt_oe = $urandom;
      pt_out = $urandom;
      mcu_out = $urandom;
      pin_in = $urandom & 32'hFFFFFF00;
      addr_latched = 8'($urandom);
      periph_data = 8'($urandom);
      ecs = 2'($urandom);
      repeat (12) @(posedge clk_sys);
      arst_n <= 1'b1;
      cyc(1);
      chk({7'h00, mem_standby}, 8'h01);
      chk(pin_oe.a, 8'h00);
      for (int i = 0; i < 4; i++) rd(st_ofs[i], 8'h00);
      rd(8'h30, 8'h00);
      done("reset");
      for (int i = 0; i < 4; i++) begin
         r = 8'($urandom);
         wr(dir_ofs[i], r);
         cyc(2);
         chk(pin_oe[31-8*i -: 8] & msk[i], r & msk[i]);
         rd(st_ofs[i], r & msk[i]);
         wr(st_ofs[i], ~r);
         rd(st_ofs[i], r & msk[i]);
         wr(drv_ofs[i], 8'hFF);
         cyc(2);
         chk(pin_fast_slew[31-8*i -: 8], fs_exp[i]);
         chk(pin_open_drain[31-8*i -: 8], od_exp[i]);
      end
      done("direction and drive");
      wr(8'h04, 8'h5A);
      wr(8'hE0, 8'h40);
      periph_sel <= 1'b1;
      periph_rd <= 1'b1;
      pt_oe.a <= 8'hC3;
      pt_oe.b <= 8'h3C;
      mode_b <= pio_pkg::PIO_MODE_OMC;
      for (int m = 0; m < 5; m++) begin
         mode_a <= pio_pkg::pio_mode_t'(m);
         cyc(2);
         if (m == 3) chk(pin_out.a, addr_latched);
         rd(8'h0C, m_exp[m]);
      end
      periph_rd <= 1'b0;
      cyc(2);
      rd(8'h0C, 8'h00);
      rd(8'h0D, 8'h3C);
      mode_d <= pio_pkg::PIO_MODE_OMC;
      cyc(2);
      chk(pin_out.d, {5'h00, ecs, 1'b0});
      rd(8'h1B, 8'h06);
      mode_d <= pio_pkg::PIO_MODE_MCU;
      done("modes");
      wr(8'h12, 8'h00);
      for (int i = 0; i < 3; i++) begin
         wr(8'hE0, cf[i]);
         rd(8'h1A, cf_exp[i]);
      end
      wr(8'hE0, 8'h38);
      cyc(2);
      chk({6'h00, pin_out.c[4:3]}, {6'h00, isp_error_flag, isp_progress_flag});
      done("status pins");
      wr(8'h13, 8'hFF);
      wr(8'hE0, 8'h06);
      rd(8'h1B, 8'h00);
      n0 = clkc;
      d1_edges(3);
      chk(8'(clkc - n0), 8'h03);
      pin_in.d[2] <= 1'b1;
      cyc(6);
      n0 = wakes;
      i_pio_host_model.move(~cpu_addr);
      cyc(4);
      chk(8'(wakes - n0), 8'h00);
      pin_in.d[2] <= 1'b0;
      cyc(6);
      i_pio_host_model.move(~cpu_addr);
      cyc(4);
      chk(8'(wakes - n0), 8'h01);
      done("dedicated pins");
      wr(8'hB0, 8'h08);
      wr(8'hE0, 8'h05);
      cyc(2);
      chk({6'h00, turbo_off, logic_zero_power}, 8'h03);
      wr(8'hB0, 8'h02);
      d1_edges(3);
      rd(8'h30, 8'h00);
      d1_edges(3);
      chk({7'h00, bus_buf_off}, 8'h00);
      d1_edges(1);
      cyc(3);
      chk({7'h00, bus_buf_off}, 8'h01);
      r = 8'($urandom);
      pin_in.b <= r;
      n0 = wakes;
      cyc(6);
      i_pio_host_model.move(~cpu_addr);
      cyc(4);
      chk(pin_to_array.b, r);
      chk(8'(wakes - n0), 8'h00);
      wr(8'hB0, 8'h00);
      cyc(3);
      chk({7'h00, bus_buf_off}, 8'h00);
      wr(8'hC7, 8'h02);
      cyc(3);
      chk({7'h00, bus_buf_off}, 8'h01);
      wr(8'hC7, 8'h00);
      cyc(3);
      chk({7'h00, bus_buf_off}, 8'h00);
      done("power down");
      tally_and_finish();
   end
endmodule : pio_port_ctrl_tb
